// ==== include/psc_pkg.sv ====
package psc_pkg;
    // Reference rate of the logic clock, kept for derived timing.
    localparam int unsigned CLOCK_MHZ = 250;
    // Positions of the pins inside the synchronised input vector.
    localparam int unsigned PIN_HW_RESET_N = 0;
    localparam int unsigned PIN_DUPLEX = 1;
    localparam int unsigned PIN_OP_LO = 2;
    localparam int unsigned PIN_OP_HI = 3;
    localparam int unsigned PIN_TX_DIS = 4;
    localparam int unsigned PIN_TX_DIS_FLOAT = 5;
    localparam int unsigned PIN_TEST_SEL = 6;
    localparam int unsigned PIN_TEST_SEL_FLOAT = 7;
    localparam int unsigned PIN_PS_THRESH = 8;
    localparam int unsigned PIN_FIBER_SD = 9;
    localparam int unsigned PIN_FIBER_SEL_N = 10;
    localparam int unsigned PIN_COUNT = 11;
    // Value during reset of the fiber, back-to-back, clock-direction, transmit-disable and loopback outputs.
    localparam logic CTRL_RESET = 1'h0;
    // Power-saving control bit location in the management map.
    localparam logic [4:0] PS_REG_ADDR = 5'h1F;
    localparam int unsigned PS_REG_BIT = 15;
endpackage

// ==== hdl/psc_strap_config.sv ====
`timescale 1ns/1ps
// Functional notes
// R1 - All logic runs from the single reference-derived system clock.
// R2 - Duplex strap is sampled during reset; high means full duplex.
// R3 - Two operating-select straps are latched at reset and power-up.
// R4 - Active-low hardware reset forces all logic to a known state. The code leaves the two pin synchroniser stages running under reset.
// R5 - Transmit-disable strap high suppresses transmit; floating means normal. The code suppresses transmit only while test-select is also high.
// R6 - Disable and test-select pins decode to transmit-off or loopback.
// R7 - Power-saving bit starts from its strap; low disables, else enables.
// R8 - In fiber mode that strap selects signal-detect threshold instead.
// R9 - Fiber signal-detect input reports fiber receive signal presence.
// R10 - Test-select high gives back-to-back mode; transmit clock is input.
// R11 - Low active-low fiber-select input places the device in fiber mode.
// R12 - Captured straps stay stable until the next reset.
module psc_strap_config (
    input wire logic I_CLOCK, // System clock, 250 MHz.
    input wire logic I_SYS_RST, // Synchronous reset, active high.
    input wire logic I_HW_RESET_N, // Hardware reset pin, active low.
    input wire logic I_DUPLEX_STRAP, // Duplex strap pin.
    input wire logic I_OP_SELECT_STRAP_LO, // Operating-select strap, bit 0.
    input wire logic I_OP_SELECT_STRAP_HI, // Operating-select strap, bit 1.
    input wire logic I_TX_DISABLE_LOOP_STRAP, // Transmit-disable pin level.
    input wire logic I_TX_DISABLE_LOOP_FLOAT, // Pad sees that pin floating.
    input wire logic I_TEST_SELECT_PIN, // Test-select pin level.
    input wire logic I_TEST_SELECT_FLOAT, // Pad sees test-select floating.
    input wire logic I_POWER_SAVE_THRESHOLD_STRAP, // Power-save strap pin.
    input wire logic I_FIBER_SIGNAL_DETECT, // Fiber signal-detect pin.
    input wire logic I_FIBER_SELECT_N, // Fiber select pin, active low.
    input wire logic I_POWER_SAVE_WR, // Management write of power-save bit.
    input wire logic I_POWER_SAVE_WDATA, // Value for that write.
    output logic O_LOGIC_RESET, // Internal reset in force.
    output logic O_FULL_DUPLEX, // Captured duplex strap.
    output logic [1:0] O_OP_SELECT, // Captured operating-select code.
    output logic O_POWER_SAVE, // Power-saving control bit.
    output logic O_FIBER_SIGNAL_DETECT_THRESHOLD, // Fiber signal-detect threshold select.
    output logic O_FIBER_MODE, // Fiber mode selected.
    output logic O_FIBER_SIGNAL, // Fiber receive signal present.
    output logic O_BACK_TO_BACK, // Back-to-back media converter mode.
    output logic O_TXC_IS_INPUT, // Transmit clock pin turned to input.
    output logic O_TX_DISABLE, // Transmit suppressed.
    output logic O_LOCAL_LOOPBACK, // Local loopback selected.
    output logic O_REMOTE_LOOPBACK // Remote loopback selected.
);
    localparam int unsigned N = psc_pkg::PIN_COUNT;

    logic [N-1:0] pin_meta;
    logic [N-1:0] pin;
    wire [N-1:0] pin_raw = {I_FIBER_SELECT_N, I_FIBER_SIGNAL_DETECT,
        I_POWER_SAVE_THRESHOLD_STRAP, I_TEST_SELECT_FLOAT, I_TEST_SELECT_PIN,
        I_TX_DISABLE_LOOP_FLOAT, I_TX_DISABLE_LOOP_STRAP,
        I_OP_SELECT_STRAP_HI, I_OP_SELECT_STRAP_LO, I_DUPLEX_STRAP,
        I_HW_RESET_N};

    // Every pin is asynchronous to the clock, so all pass two stages. The
    // stages keep running under reset so that the straps are settled in
    // them by the time the capture registers sample them.
    always_ff @(posedge I_CLOCK) begin // R1
        pin_meta <= pin_raw;
        pin <= pin_meta;
    end

    // A pin level counts only while its pad does not sense it open.
    function automatic logic pin_driven(input logic level,
        input logic floating);
        return level & ~floating;
    endfunction

    wire in_rst = I_SYS_RST | ~pin[psc_pkg::PIN_HW_RESET_N]; // R4
    wire dis_float = pin[psc_pkg::PIN_TX_DIS_FLOAT];
    wire dis_high = pin_driven(pin[psc_pkg::PIN_TX_DIS], dis_float);
    wire dis_low = pin_driven(~pin[psc_pkg::PIN_TX_DIS], dis_float);
    wire tst_float = pin[psc_pkg::PIN_TEST_SEL_FLOAT];
    wire tst_high = pin_driven(pin[psc_pkg::PIN_TEST_SEL], tst_float);
    wire fiber = ~pin[psc_pkg::PIN_FIBER_SEL_N]; // R11
    wire ps_strap = pin[psc_pkg::PIN_PS_THRESH];
    wire next_tx_disable = dis_high & tst_high; // R5 R6
    wire next_local_loop = dis_high & tst_float; // R6
    wire next_remote_loop = dis_low; // R6
    wire next_signal = fiber & pin[psc_pkg::PIN_FIBER_SD]; // R9
    // In fiber mode the strap feeds the threshold and power saving is off.
    wire next_ps_init = fiber ? 1'h0 : ps_strap; // R7 R8

    // Straps follow the pins while reset lasts and freeze at its release.
    always_ff @(posedge I_CLOCK) begin
        if (in_rst) begin
            O_FULL_DUPLEX <= pin[psc_pkg::PIN_DUPLEX]; // R2 R12
            O_OP_SELECT <= {pin[psc_pkg::PIN_OP_HI],
                pin[psc_pkg::PIN_OP_LO]}; // R3 R12
            O_FIBER_SIGNAL_DETECT_THRESHOLD <= ps_strap & fiber; // R8 R12
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (in_rst) begin
            O_POWER_SAVE <= next_ps_init; // R7
        end else if (I_POWER_SAVE_WR) begin
            O_POWER_SAVE <= I_POWER_SAVE_WDATA;
        end
    end

    always_ff @(posedge I_CLOCK) begin
        O_LOGIC_RESET <= in_rst;
        if (in_rst) begin
            O_FIBER_MODE <= psc_pkg::CTRL_RESET; // R4
            O_FIBER_SIGNAL <= psc_pkg::CTRL_RESET;
            O_BACK_TO_BACK <= psc_pkg::CTRL_RESET;
            O_TXC_IS_INPUT <= psc_pkg::CTRL_RESET;
            O_TX_DISABLE <= psc_pkg::CTRL_RESET;
            O_LOCAL_LOOPBACK <= psc_pkg::CTRL_RESET;
            O_REMOTE_LOOPBACK <= psc_pkg::CTRL_RESET;
        end else begin
            O_FIBER_MODE <= fiber; // R11
            O_FIBER_SIGNAL <= next_signal; // R9
            O_BACK_TO_BACK <= tst_high; // R10
            O_TXC_IS_INPUT <= tst_high; // R10
            O_TX_DISABLE <= next_tx_disable;
            O_LOCAL_LOOPBACK <= next_local_loop;
            O_REMOTE_LOOPBACK <= next_remote_loop;
        end
    end

    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (I_SYS_RST);

    sequence s_in_reset;
        in_rst;
    endsequence
    sequence s_running;
        !in_rst;
    endsequence
    sequence s_release;
        in_rst ##1 !in_rst;
    endsequence

    a_duplex_capture: assert property ( // R2
        s_in_reset |=> O_FULL_DUPLEX == $past(pin[psc_pkg::PIN_DUPLEX]))
        else $error("duplex strap not captured during reset");
    a_op_capture: assert property ( // R3
        s_in_reset |=> O_OP_SELECT == {$past(pin[psc_pkg::PIN_OP_HI]),
            $past(pin[psc_pkg::PIN_OP_LO])})
        else $error("operating-select straps not captured");
    a_strap_hold: assert property ( // R12
        s_running ##1 s_running |-> $stable(O_FULL_DUPLEX)
            && $stable(O_OP_SELECT) && $stable(O_FIBER_SIGNAL_DETECT_THRESHOLD))
        else $error("captured strap changed outside reset");
    a_reset_clear: assert property ( // R4
        s_in_reset |=> O_LOGIC_RESET && !O_TX_DISABLE && !O_LOCAL_LOOPBACK
            && !O_REMOTE_LOOPBACK && !O_FIBER_MODE && !O_BACK_TO_BACK)
        else $error("controls not cleared under reset");
    a_float_normal: assert property ( // R5
        s_running and dis_float |=> !O_TX_DISABLE && !O_LOCAL_LOOPBACK
            && !O_REMOTE_LOOPBACK)
        else $error("floating strap did not give normal operation");
    a_loop_decode: assert property ( // R6
        s_running |=> O_TX_DISABLE == $past(dis_high && tst_high)
            && O_LOCAL_LOOPBACK == $past(dis_high && tst_float)
            && O_REMOTE_LOOPBACK == $past(dis_low))
        else $error("transmit-disable and loopback decode wrong");
    a_ps_init: assert property ( // R7
        s_in_reset ##1 s_running |-> O_POWER_SAVE
            == ($past(ps_strap) && !$past(fiber)))
        else $error("power-saving bit not initialised from strap");
    a_fx_threshold: assert property ( // R8
        s_in_reset |=> O_FIBER_SIGNAL_DETECT_THRESHOLD == $past(ps_strap && fiber))
        else $error("fiber threshold not taken from strap");
    a_signal_detect: assert property ( // R9
        s_running |=> O_FIBER_SIGNAL == $past(next_signal))
        else $error("fiber signal detect not reported");
    a_back_to_back: assert property ( // R10
        s_running and tst_high |=> O_BACK_TO_BACK && O_TXC_IS_INPUT)
        else $error("back-to-back mode not entered");
    a_fiber_select: assert property ( // R11
        s_running |=> O_FIBER_MODE == !$past(pin[psc_pkg::PIN_FIBER_SEL_N]))
        else $error("fiber select not followed");

    a_sync_stages: assert property ( // R1
        pin == $past(pin_raw, 2))
        else $error("pin synchroniser is not two stages deep");
    a_reset_flag: assert property ( // R4
        O_LOGIC_RESET == $past(in_rst))
        else $error("reset flag does not follow internal reset");
    a_release_flag: assert property ( // R4
        s_release |=> !O_LOGIC_RESET)
        else $error("reset flag stuck after release");
    a_reset_quiet: assert property ( // R4
        s_in_reset |=> !O_FIBER_SIGNAL && !O_TXC_IS_INPUT)
        else $error("fiber signal or clock direction set under reset");
    a_disable_b2b: assert property ( // R5
        O_TX_DISABLE |-> O_BACK_TO_BACK)
        else $error("transmit disabled outside media converter mode");
    a_loop_onehot: assert property ( // R6
        $onehot0({O_TX_DISABLE, O_LOCAL_LOOPBACK, O_REMOTE_LOOPBACK}))
        else $error("more than one loop mode selected");
    a_remote_loop: assert property ( // R6
        s_running and dis_low |=> O_REMOTE_LOOPBACK)
        else $error("low disable pin did not give remote loopback");
    a_local_loop: assert property ( // R6
        s_running and dis_high and tst_float |=> O_LOCAL_LOOPBACK)
        else $error("high disable with open test pin not local loop");
    a_ps_copper: assert property ( // R7
        s_in_reset and !fiber |=> O_POWER_SAVE == $past(ps_strap))
        else $error("power-saving bit not loaded from strap");
    a_ps_write: assert property ( // R7
        s_running and I_POWER_SAVE_WR
            |=> O_POWER_SAVE == $past(I_POWER_SAVE_WDATA))
        else $error("power-saving write not applied");
    a_ps_hold: assert property ( // R7
        s_running and !I_POWER_SAVE_WR |=> $stable(O_POWER_SAVE))
        else $error("power-saving bit changed without a write");
    a_ps_fiber_off: assert property ( // R8
        s_in_reset and fiber |=> !O_POWER_SAVE)
        else $error("power saving set in fiber mode");
    a_thresh_copper: assert property ( // R8
        s_in_reset and !fiber |=> !O_FIBER_SIGNAL_DETECT_THRESHOLD)
        else $error("threshold select set outside fiber mode");
    a_signal_on: assert property ( // R9
        s_running and next_signal |=> O_FIBER_SIGNAL)
        else $error("fiber signal not reported");
    a_no_fiber_signal: assert property ( // R9
        !O_FIBER_MODE |-> !O_FIBER_SIGNAL)
        else $error("fiber signal reported outside fiber mode");
    a_txc_input: assert property ( // R10
        O_TXC_IS_INPUT == O_BACK_TO_BACK)
        else $error("transmit clock direction differs from mode");
    a_b2b_off: assert property ( // R10
        s_running and !tst_high |=> !O_BACK_TO_BACK)
        else $error("back-to-back mode without test pin high");
    a_copper_mode: assert property ( // R11
        s_running and !fiber |=> !O_FIBER_MODE)
        else $error("fiber mode without fiber select");
endmodule

// ==== dv/psc_board_model.sv ====
`timescale 1ns/1ps
module psc_board_model (
    input wire logic i_clock, // Bench clock, paces the open-pin pattern.
    input wire logic [10:0] i_cfg, // Wanted levels and float flags.
    output logic [10:0] o_pins // Levels seen at the pads.
);
    logic wobble = 1'h0;
    // An open pin has no pull, so its level wanders every cycle.
    always @(negedge i_clock) begin
        wobble <= ~wobble;
    end
    always_comb begin
        o_pins = i_cfg;
        if (i_cfg[psc_pkg::PIN_TX_DIS_FLOAT]) begin
            o_pins[psc_pkg::PIN_TX_DIS] = wobble;
        end
        if (i_cfg[psc_pkg::PIN_TEST_SEL_FLOAT]) begin
            o_pins[psc_pkg::PIN_TEST_SEL] = wobble;
        end
    end
endmodule

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
module testbench;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic wr = 1'h0;
    logic wd = 1'h0;
    logic [10:0] cfg = 11'h587;
    wire logic [10:0] p;
    logic lr, fd, pw, th, fm, fs, bb, tci, td, ll, rl;
    logic [1:0] op;
    logic [5:0] e;
    logic [11:0] rows [6] = '{12'h964, 12'hA50, 12'h90C, 12'hA08, 12'h443,
        12'h984};
    int mismatches = 0;
    int compares = 0;
    always #2 clk = ~clk;
    psc_board_model psc_board_model_i (.i_clock(clk), .i_cfg(cfg),
        .o_pins(p));
    psc_strap_config psc_strap_config_i (
        .I_CLOCK(clk), .I_SYS_RST(rst), .I_HW_RESET_N(p[0]),
        .I_DUPLEX_STRAP(p[1]), .I_OP_SELECT_STRAP_LO(p[2]),
        .I_OP_SELECT_STRAP_HI(p[3]), .I_TX_DISABLE_LOOP_STRAP(p[4]),
        .I_TX_DISABLE_LOOP_FLOAT(p[5]), .I_TEST_SELECT_PIN(p[6]),
        .I_TEST_SELECT_FLOAT(p[7]), .I_POWER_SAVE_THRESHOLD_STRAP(p[8]),
        .I_FIBER_SIGNAL_DETECT(p[9]), .I_FIBER_SELECT_N(p[10]),
        .I_POWER_SAVE_WR(wr), .I_POWER_SAVE_WDATA(wd),
        .O_LOGIC_RESET(lr), .O_FULL_DUPLEX(fd), .O_OP_SELECT(op),
        .O_POWER_SAVE(pw), .O_FIBER_SIGNAL_DETECT_THRESHOLD(th), .O_FIBER_MODE(fm),
        .O_FIBER_SIGNAL(fs), .O_BACK_TO_BACK(bb), .O_TXC_IS_INPUT(tci),
        .O_TX_DISABLE(td), .O_LOCAL_LOOPBACK(ll), .O_REMOTE_LOOPBACK(rl)
    );
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic do_reset(input logic [10:0] c);
        cfg = c;
        rst = 1'h1;
        repeat (5) @(negedge clk);
        check({lr, rl}, 2'h2);
        rst = 1'h0;
        repeat (4) @(negedge clk);
    endtask
    task automatic caps(input logic [4:0] x);
        check({fd, op, pw, th}, x);
    endtask
    initial begin
        do_reset(11'h587);
        caps(5'h16);
        check({lr, rl}, 2'h1);
        // Straps move after reset; captured values must not.
        cfg = cfg ^ 11'h10E;
        repeat (4) @(negedge clk);
        caps(5'h16);
        foreach (rows[i]) begin
            {cfg[10:9], cfg[7:4]} = rows[i][11:6];
            e = rows[i][5:0];
            repeat (4) @(negedge clk);
            check({td, ll, rl, bb, fm, fs}, e);
            check(tci, e[2]);
        end
        wr = 1'h1;
        wd = 1'h0;
        @(negedge clk);
        wd = 1'h1;
        check(pw, 1'h0);
        @(negedge clk);
        wr = 1'h0;
        check(pw, 1'h1);
        do_reset(11'h1A9);
        caps(5'h09);
        do_reset(11'h4A9);
        caps(5'h08);
        cfg = 11'h586;
        repeat (4) @(negedge clk);
        check({lr, rl}, 2'h2);
        cfg[0] = 1'h1;
        repeat (6) @(negedge clk);
        caps(5'h16);
        check({lr, rl}, 2'h1);
        finish_test();
    end
    initial begin
        #2000;
        mismatches++;
        finish_test();
    end
endmodule
